// ==== include/dav_pkg.sv ====
package dav_pkg;
   // ****************************************
   // Clock and sample timing
   // ****************************************
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned SAMPLE_RATE_SPS = 2000;
   localparam int unsigned SAMPLE_DIV_CYC = CLK_HZ / SAMPLE_RATE_SPS;
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned ACC_W = 48;
   localparam int unsigned NCH = 4;
   localparam int unsigned DEC_W = 16;

   // ****************************************
   // Register byte addresses
   // ****************************************
   localparam logic [6:0] Y_DANGLE_LOW = 7'h28;
   localparam logic [6:0] Y_DANGLE_HIGH = 7'h2A;
   localparam logic [6:0] Z_DANGLE_LOW = 7'h2C;
   localparam logic [6:0] Z_DANGLE_HIGH = 7'h2E;
   localparam logic [6:0] X_DVEL_LOW = 7'h30;
   localparam logic [6:0] X_DVEL_HIGH = 7'h32;
   localparam logic [6:0] Y_DVEL_LOW = 7'h34;
   localparam logic [6:0] Y_DVEL_HIGH = 7'h36;
   localparam logic [6:0] ADDR_PAIR_MASK = 7'h7E;

   // ****************************************
   // Data format
   // ****************************************
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;
   localparam logic [31:0] RESULT_RESET = 32'h00000000;
   localparam logic [31:0] POS_FULL32 = 32'h7FFFFFFF;
   localparam logic [31:0] NEG_FULL32 = 32'h80000000;
   localparam int unsigned DVEL_RANGE_MPS = 400;
   localparam logic [11:0] DANGLE_RANGE_0 = 12'h168;
   localparam logic [11:0] DANGLE_RANGE_1 = 12'h2D0;
   localparam logic [11:0] DANGLE_RANGE_2 = 12'h870;
endpackage

// ==== hw/dav_delta_out.sv ====
`timescale 1ns/1ps
module dav_delta_out #(
   parameter int unsigned SAMPLE_DIV = dav_pkg::SAMPLE_DIV_CYC,
   parameter int unsigned SAMPLE_W = dav_pkg::SAMPLE_W,
   parameter int unsigned RANGE_SEL = 0
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic signed [SAMPLE_W-1:0] gyro_y_in,
   input wire logic signed [SAMPLE_W-1:0] gyro_z_in,
   input wire logic signed [SAMPLE_W-1:0] accl_x_in,
   input wire logic signed [SAMPLE_W-1:0] accl_y_in,
   input wire logic [dav_pkg::DEC_W-1:0] decimation_setting_in,
   input wire logic rd_en_in,
   input wire logic [6:0] rd_addr_in,
   output logic [15:0] rd_data_out,
   output logic update_out,
   output logic [11:0] dangle_range_deg_out
);
   localparam int unsigned AW = dav_pkg::ACC_W;
   localparam int unsigned NCH = dav_pkg::NCH;

   // ****************************************
   // Parameter checks
   // ****************************************
   if (SAMPLE_W < 2 || SAMPLE_W > 24 ||
      SAMPLE_DIV < 16 || RANGE_SEL > 2) begin : g_bad
      $error("dav_delta_out: unsupported parameter value");
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic signed [AW-1:0] trap(
      input logic signed [AW-1:0] acc_v,
      input logic signed [SAMPLE_W-1:0] cur_v,
      input logic signed [SAMPLE_W-1:0] old_v);
      trap = acc_v + AW'(cur_v) + AW'(old_v);
   endfunction

   function automatic logic [31:0] sat32(input logic signed [AW-1:0] v);
      if (v > AW'(signed'(dav_pkg::POS_FULL32))) begin
         sat32 = dav_pkg::POS_FULL32;
      end else if (v < -AW'(signed'({1'b0, dav_pkg::NEG_FULL32}))) begin
         sat32 = dav_pkg::NEG_FULL32;
      end else begin
         sat32 = v[31:0];
      end
   endfunction

   function automatic logic [11:0] range_of(input int unsigned sel);
      case (sel)
         0: range_of = dav_pkg::DANGLE_RANGE_0;
         1: range_of = dav_pkg::DANGLE_RANGE_1;
         default: range_of = dav_pkg::DANGLE_RANGE_2;
      endcase
   endfunction

   // ****************************************
   // Sample rate divider
   // ****************************************
   logic [31:0] div_cnt;
   logic [31:0] next_div_cnt;
   logic sample_stb;
   logic next_sample_stb;

   always_comb begin
      next_div_cnt = div_cnt + 32'h00000001;
      next_sample_stb = 1'b0;
      if (div_cnt == 32'(SAMPLE_DIV - 1)) begin
         next_div_cnt = 32'h00000000;
         next_sample_stb = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         div_cnt <= 32'h00000000;
         sample_stb <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         sample_stb <= next_sample_stb;
      end
   end

   // ****************************************
   // Trapezoid integrators
   // ****************************************
   logic signed [SAMPLE_W-1:0] smp [NCH];
   logic signed [SAMPLE_W-1:0] prev [NCH];
   logic signed [SAMPLE_W-1:0] next_prev [NCH];
   logic signed [AW-1:0] acc [NCH];
   logic signed [AW-1:0] next_acc [NCH];
   logic [31:0] result [NCH];
   logic [31:0] next_result [NCH];
   logic [dav_pkg::DEC_W-1:0] dec_cnt;
   logic [dav_pkg::DEC_W-1:0] next_dec_cnt;
   logic upd;
   logic next_upd;
   logic span_end;

   assign smp[0] = gyro_y_in;
   assign smp[1] = gyro_z_in;
   assign smp[2] = accl_x_in;
   assign smp[3] = accl_y_in;
   assign span_end = dec_cnt >= decimation_setting_in;

   always_comb begin
      next_dec_cnt = dec_cnt;
      next_upd = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         next_prev[i] = prev[i];
         next_acc[i] = acc[i];
         next_result[i] = result[i];
      end
      if (sample_stb) begin
         next_dec_cnt = dec_cnt + 16'h0001;
         for (int i = 0; i < NCH; i++) begin
            next_prev[i] = smp[i];
            next_acc[i] = trap(acc[i], smp[i], prev[i]);
         end
         if (span_end) begin
            next_dec_cnt = 16'h0000;
            next_upd = 1'b1;
            for (int i = 0; i < NCH; i++) begin
               next_acc[i] = '0;
               next_result[i] = sat32(trap(acc[i], smp[i], prev[i]));
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         dec_cnt <= 16'h0000;
         upd <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            prev[i] <= '0;
            acc[i] <= '0;
            result[i] <= dav_pkg::RESULT_RESET;
         end
      end else begin
         dec_cnt <= next_dec_cnt;
         upd <= next_upd;
         for (int i = 0; i < NCH; i++) begin
            prev[i] <= next_prev[i];
            acc[i] <= next_acc[i];
            result[i] <= next_result[i];
         end
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   logic [15:0] next_rd_data;
   logic [11:0] next_range;

   always_comb begin
      next_rd_data = dav_pkg::RD_UNMAPPED;
      next_range = range_of(RANGE_SEL);
      if (rd_en_in) begin
         case (rd_addr_in & dav_pkg::ADDR_PAIR_MASK)
            dav_pkg::Y_DANGLE_LOW: next_rd_data = result[0][15:0];
            dav_pkg::Y_DANGLE_HIGH: next_rd_data = result[0][31:16];
            dav_pkg::Z_DANGLE_LOW: next_rd_data = result[1][15:0];
            dav_pkg::Z_DANGLE_HIGH: next_rd_data = result[1][31:16];
            dav_pkg::X_DVEL_LOW: next_rd_data = result[2][15:0];
            dav_pkg::X_DVEL_HIGH: next_rd_data = result[2][31:16];
            dav_pkg::Y_DVEL_LOW: next_rd_data = result[3][15:0];
            dav_pkg::Y_DVEL_HIGH: next_rd_data = result[3][31:16];
            default: next_rd_data = dav_pkg::RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         rd_data_out <= 16'h0000;
         dangle_range_deg_out <= 12'h000;
      end else begin
         rd_data_out <= next_rd_data;
         dangle_range_deg_out <= next_range;
      end
   end

   assign update_out = upd;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_span_end;
      sample_stb && span_end;
   endsequence

   sequence s_mid_span;
      sample_stb && !span_end;
   endsequence

   vel_trap_a: assert property (s_span_end |=>
      result[2] == sat32(trap($past(acc[2]), $past(smp[2]), $past(prev[2]))))
      else $error("velocity result differs from trapezoid sum");
   ang_trap_a: assert property (s_span_end |=>
      result[1] == sat32(trap($past(acc[1]), $past(smp[1]), $past(prev[1]))))
      else $error("angle result differs from trapezoid sum");
   acc_restart_a: assert property (s_span_end |=> acc[3] == '0 && upd)
      else $error("accumulator not restarted at update");
   span_count_a: assert property (s_mid_span |=> !upd &&
      dec_cnt == $past(dec_cnt) + 16'h0001)
      else $error("span counter did not advance");
   sample_gap_a: assert property (sample_stb |=> !sample_stb [*8])
      else $error("sample strobes too close");
   sample_rate_a: assert property (sample_stb |->
      $past(div_cnt) == 32'(SAMPLE_DIV - 1))
      else $error("sample strobe off divider count");
   pair_update_a: assert property ($changed(result[0]) |-> upd)
      else $error("result changed outside update");
   read_ylow_a: assert property (rd_en_in &&
      rd_addr_in == dav_pkg::Y_DANGLE_LOW |=>
      rd_data_out == $past(result[0][15:0]))
      else $error("y angle low word read wrong");
   read_zhigh_a: assert property (rd_en_in &&
      rd_addr_in == dav_pkg::Z_DANGLE_HIGH |=>
      rd_data_out == $past(result[1][31:16]))
      else $error("z angle high word read wrong");
   read_xvel_a: assert property (rd_en_in &&
      rd_addr_in == dav_pkg::X_DVEL_HIGH |=>
      rd_data_out == $past(result[2][31:16]))
      else $error("x velocity high word read wrong");
   read_idle_a: assert property (!rd_en_in |=> rd_data_out == 16'h0000)
      else $error("read data not cleared when idle");
   range_out_a: assert property (upd |->
      dangle_range_deg_out == range_of(RANGE_SEL))
      else $error("angle range output wrong");

   // ****************************************
   // Further datapath and read assertions
   // ****************************************
   vel_ytrap_a: assert property (s_span_end |=>
      result[3] == sat32(trap($past(acc[3]), $past(smp[3]), $past(prev[3]))))
      else $error("y velocity result differs from trapezoid sum");
   ang_ytrap_a: assert property (s_span_end |=>
      result[0] == sat32(trap($past(acc[0]), $past(smp[0]), $past(prev[0]))))
      else $error("y angle result differs from trapezoid sum");
   acc_step_a: assert property (s_mid_span |=>
      acc[0] == trap($past(acc[0]), $past(smp[0]), $past(prev[0])))
      else $error("accumulator did not add the sample pair");
   prev_load_a: assert property (sample_stb |=>
      prev[1] == $past(smp[1]))
      else $error("previous sample not captured");
   span_restart_a: assert property (s_span_end |=> dec_cnt == 16'h0000)
      else $error("span counter not restarted");
   idle_hold_a: assert property (!sample_stb |=>
      $stable(acc[1]) && $stable(dec_cnt))
      else $error("integrator moved between strobes");
   result_hold_a: assert property (!(sample_stb && span_end) |=>
      $stable(result[3]))
      else $error("y velocity result changed outside update");
   upd_pulse_a: assert property (upd |=> !upd)
      else $error("update pulse longer than one cycle");
   div_bound_a: assert property (div_cnt < 32'(SAMPLE_DIV))
      else $error("sample divider out of range");
   read_yhigh_a: assert property (rd_en_in &&
      (rd_addr_in & dav_pkg::ADDR_PAIR_MASK) == dav_pkg::Y_DANGLE_HIGH |=>
      rd_data_out == $past(result[0][31:16]))
      else $error("y angle high word read wrong");
   read_zlow_a: assert property (rd_en_in &&
      (rd_addr_in & dav_pkg::ADDR_PAIR_MASK) == dav_pkg::Z_DANGLE_LOW |=>
      rd_data_out == $past(result[1][15:0]))
      else $error("z angle low word read wrong");
   read_xlow_a: assert property (rd_en_in &&
      (rd_addr_in & dav_pkg::ADDR_PAIR_MASK) == dav_pkg::X_DVEL_LOW |=>
      rd_data_out == $past(result[2][15:0]))
      else $error("x velocity low word read wrong");
   read_yvlow_a: assert property (rd_en_in &&
      (rd_addr_in & dav_pkg::ADDR_PAIR_MASK) == dav_pkg::Y_DVEL_LOW |=>
      rd_data_out == $past(result[3][15:0]))
      else $error("y velocity low word read wrong");
   read_yvhigh_a: assert property (rd_en_in &&
      (rd_addr_in & dav_pkg::ADDR_PAIR_MASK) == dav_pkg::Y_DVEL_HIGH |=>
      rd_data_out == $past(result[3][31:16]))
      else $error("y velocity high word read wrong");
   read_unmapped_a: assert property (rd_en_in &&
      ((rd_addr_in & dav_pkg::ADDR_PAIR_MASK) < dav_pkg::Y_DANGLE_LOW ||
      (rd_addr_in & dav_pkg::ADDR_PAIR_MASK) > dav_pkg::Y_DVEL_HIGH) |=>
      rd_data_out == dav_pkg::RD_UNMAPPED)
      else $error("unmapped address did not read zero");
endmodule

// ==== verif/dav_host_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Host register reader
// ****************************************
module dav_host_model (
   input wire logic sys_clk_in,
   input wire logic [15:0] rd_data_in,
   output logic rd_en_out,
   output logic [6:0] rd_addr_out
);
   initial begin
      rd_en_out = 1'b0;
      rd_addr_out = 7'h7F;
   end
   // One request edge, answer taken in the following cycle
   task automatic read_word(input logic [6:0] addr, output logic [15:0] data);
      @(posedge sys_clk_in);
      rd_en_out <= 1'b1;
      rd_addr_out <= addr;
      @(posedge sys_clk_in);
      rd_en_out <= 1'b0;
      rd_addr_out <= ~addr;
      @(negedge sys_clk_in);
      data = rd_data_in;
   endtask
endmodule

// ==== verif/tb_delta_angle_velocity_out.sv ====
`timescale 1ns/1ps
module tb_delta_angle_velocity_out;
   logic sys_clk_in;
   logic reset_n_in;
   logic signed [15:0] smp [4];
   logic [15:0] dec;
   logic rd_en;
   logic [6:0] rd_addr;
   logic [15:0] rd_data;
   logic update;
   logic [11:0] range_deg;
   int miscompares;
   int compares;
   localparam int CLK_NS = 8;
   localparam int DIV = 16;
   // ****************************************
   // Design and host
   // ****************************************
   dav_delta_out #(.SAMPLE_DIV(DIV), .RANGE_SEL(1)) dut_u (
      .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .gyro_y_in(smp[0]), .gyro_z_in(smp[1]),
      .accl_x_in(smp[2]), .accl_y_in(smp[3]),
      .decimation_setting_in(dec), .rd_en_in(rd_en),
      .rd_addr_in(rd_addr), .rd_data_out(rd_data),
      .update_out(update), .dangle_range_deg_out(range_deg));
   dav_host_model host_u (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data),
      .rd_en_out(rd_en), .rd_addr_out(rd_addr));
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_update(output int cyc);
      for (cyc = 1; cyc < 2000; cyc++) begin
         @(negedge sys_clk_in);
         if (update === 1'b1) break;
      end
      if (cyc >= 2000) begin
         miscompares++;
         $display("ERROR t=%0t no update within bound", $time);
         print_verdict();
      end
   endtask
   task automatic read_all(input int k, input int n);
      logic [15:0] w;
      logic [31:0] exp;
      for (int i = 0; i < n; i++) begin
         exp = 32'(k * int'(smp[i]));
         host_u.read_word(7'h28 + 7'(4 * i), w);
         check({16'h0000, w}, {16'h0000, exp[15:0]});
         host_u.read_word(7'h2A + 7'(4 * i), w);
         check({16'h0000, w}, {16'h0000, exp[31:16]});
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic run_span(input logic [15:0] dec_val, input int n);
      int cyc;
      time t_up;
      @(posedge sys_clk_in);
      reset_n_in <= 1'b0;
      dec <= dec_val;
      repeat (3) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      wait_update(cyc);
      t_up = $time;
      @(negedge sys_clk_in);
      check({31'h0, update}, 32'h0);
      read_all(2 * int'(dec_val) + 1, n);
      wait_update(cyc);
      check(32'(($time - t_up) / CLK_NS),
         32'(DIV * (int'(dec_val) + 1)));
      read_all(2 * int'(dec_val) + 2, n);
   endtask
   task automatic misc_reads();
      logic [15:0] w;
      host_u.read_word(7'h35, w);
      check({16'h0000, w}, 32'h00000000);
      host_u.read_word(7'h37, w);
      check({16'h0000, w}, 32'h0000FFFD);
      host_u.read_word(7'h3A, w);
      check({16'h0000, w}, 32'h00000000);
      host_u.read_word(7'h26, w);
      check({16'h0000, w}, 32'h00000000);
      check({20'h00000, range_deg}, 32'h000002D0);
   endtask
   initial begin
      miscompares = 0;
      compares = 0;
      reset_n_in = 1'b0;
      dec = 16'h0000;
      smp[0] = 16'sh0003;
      smp[1] = -16'sd2;
      smp[2] = 16'sh7FFF;
      smp[3] = 16'sh8000;
      run_span(16'h0002, 4);
      misc_reads();
      run_span(16'h0000, 1);
      print_verdict();
   end
endmodule
